// File: rtl/wrsa_pkg.sv
// Notes on behaviour
// - Seven-bit wiper closes one of 128 taps.
// - Power-up loads wiper from stored value.
// - Wiper writes drop data MSB; reads return MSB as zero.
// - Acknowledge address, register and data bytes.
// - Wiper write touches volatile wiper only, then standby.
// - Acknowledge both step header bytes.
// - Step: data high raises, low lowers.
// - Stop after stepping keeps last position.
// - Stepping saturates at both ends.
// - Acknowledge three bytes, then send wiper or stored byte per bank select.
// - Bank select at 02h, three-byte write.
// - 80h selects wiper, 00h selects stored.
// - Respond only when address bits match pins.
// - Last address bit: one read, zero write.
package wrsa_pkg;
	localparam int WIPER_W = 7;
	localparam int TAP_N = 128;
	localparam logic [7:0] REG_WIPER_OFS = 8'h00;
	localparam logic [7:0] REG_BANK_OFS = 8'h02;
	localparam logic [7:0] BANK_WIPER = 8'h80;
	localparam logic [7:0] BANK_STORED = 8'h00;
	localparam logic [7:0] BANK_RESET = 8'h00;
	localparam logic [6:0] WIPER_MAX = 7'h7f;
	localparam logic [6:0] WIPER_MIN = 7'h00;
	localparam int SA_TYPE_MSB = 7;
	localparam int SA_TYPE_LSB = 3;
	localparam int SA_ADDR_HI_BIT = 2;
	localparam int SA_ADDR_LO_BIT = 1;
	localparam int SA_RW_BIT = 0;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] TX_LAST = 4'h7;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_DEV = 4'b0001,
		ST_REG = 4'b0010,
		ST_DATA = 4'b0011,
		ST_ACK = 4'b0100,
		ST_STEP = 4'b0101,
		ST_TX = 4'b0110,
		ST_WAIT = 4'b0111
	} wrsa_state_e;
endpackage

// File: rtl/wrsa_sync.sv
`timescale 1ns/1ps
module wrsa_sync import wrsa_pkg::*; #(
	parameter int W = 4,
	parameter logic [W-1:0] RST = '1
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Asynchronous levels in, synchronised levels out
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] q;
	} wrsa_sync_s;

	wrsa_sync_s s_reg;
	wrsa_sync_s s_next;

	always_comb begin
		s_next = s_reg;
		for (int b = 0; b < W; b++) begin
			s_next.meta[b] = i_d[b];
			s_next.q[b] = s_reg.meta[b];
		end
		if (!i_rst_n) begin
			s_next.meta = RST;
			s_next.q = RST;
		end
	end

	always_ff @(posedge i_clk) begin
		s_reg <= s_next;
	end

	assign o_q = s_reg.q;
endmodule

// File: rtl/wrsa_slave.sv
`timescale 1ns/1ps
module wrsa_slave import wrsa_pkg::*; #(
	// Device-type codes; values are arbitrary
	parameter logic [4:0] TYPE_RW = 5'h0c,
	parameter logic [4:0] TYPE_STEP = 5'h0d
) (
	// Clock and reset (reset doubles as power-up)
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Two-wire bus, open drain data
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe,
	// Address-select straps
	input wire logic i_address_select_high,
	input wire logic i_address_select_low,
	// Nonvolatile stored wiper value
	input wire logic [WIPER_W-1:0] i_stored_wiper,
	// Wiper outputs
	output logic [WIPER_W-1:0] o_wiper_pos,
	output logic [TAP_N-1:0] o_tap_select
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		wrsa_state_e st;
		wrsa_state_e ack_to;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [7:0] dat;
		logic [7:0] reg_addr;
		logic [7:0] bank;
		logic [WIPER_W-1:0] wiper;
		logic [WIPER_W-1:0] stored;
		logic [TAP_N-1:0] tap;
		logic step;
		logic pend;
		logic sda_oe;
		logic scl_d;
		logic sda_d;
	} wrsa_slave_s;

	wrsa_slave_s r_reg;
	wrsa_slave_s r_next;
	logic [3:0] sync_q;
	logic scl;
	logic sda;
	logic rise;
	logic fall;
	logic start;
	logic stop;
	logic wiper_sel;
	logic addr_ok;
	logic type_ok;

	wrsa_sync #(.W(4), .RST(4'hf)) u_sync (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_d({i_scl, i_sda, i_address_select_high, i_address_select_low}),
		.o_q(sync_q)
	);

	// ****************************************
	// Bus event detection
	// ****************************************
	assign scl = sync_q[3];
	assign sda = sync_q[2];
	assign rise = scl & ~r_reg.scl_d;
	assign fall = ~scl & r_reg.scl_d;
	assign start = scl & r_reg.scl_d & r_reg.sda_d & ~sda;
	assign stop = scl & r_reg.scl_d & ~r_reg.sda_d & sda;
	assign wiper_sel = (r_reg.bank == BANK_WIPER);
	assign addr_ok = (r_reg.sh[SA_ADDR_HI_BIT] == sync_q[1])
		&& (r_reg.sh[SA_ADDR_LO_BIT] == sync_q[0]);
	assign type_ok = (r_reg.sh[SA_TYPE_MSB:SA_TYPE_LSB] == TYPE_RW)
		|| ((r_reg.sh[SA_TYPE_MSB:SA_TYPE_LSB] == TYPE_STEP) && !r_reg.sh[SA_RW_BIT]);

	// ****************************************
	// Protocol engine
	// ****************************************
	always_comb begin
		r_next = r_reg;
		r_next.scl_d = scl;
		r_next.sda_d = sda;
		if (!i_rst_n) begin
			r_next = '0;
			r_next.st = ST_IDLE;
			r_next.ack_to = ST_IDLE;
			r_next.bank = BANK_RESET;
			r_next.wiper = i_stored_wiper;
			r_next.stored = i_stored_wiper;
			r_next.scl_d = 1'b1;
			r_next.sda_d = 1'b1;
		end else if (stop) begin
			// Writes commit only on a clean stop
			if (r_reg.pend) begin
				if (r_reg.reg_addr == REG_BANK_OFS) begin
					r_next.bank = r_reg.dat;
				end else if (wiper_sel) begin
					r_next.wiper = r_reg.dat[WIPER_W-1:0];
				end
			end
			r_next.pend = 1'b0;
			r_next.sda_oe = 1'b0;
			r_next.st = ST_IDLE;
		end else if (start) begin
			r_next.st = ST_DEV;
			r_next.cnt = 4'h0;
			r_next.sda_oe = 1'b0;
			r_next.pend = 1'b0;
		end else begin
			case (r_reg.st)
				ST_DEV, ST_REG, ST_DATA: begin
					if (rise && r_reg.cnt != BYTE_BITS) begin
						r_next.sh = {r_reg.sh[6:0], sda};
						r_next.cnt = r_reg.cnt + 4'h1;
					end else if (fall && r_reg.cnt == BYTE_BITS) begin
						r_next.sda_oe = 1'b1;
						r_next.st = ST_ACK;
						if (r_reg.st == ST_DEV) begin
							r_next.step = (r_reg.sh[SA_TYPE_MSB:SA_TYPE_LSB] == TYPE_STEP);
							if (!(type_ok && addr_ok)) begin
								r_next.sda_oe = 1'b0;
								r_next.st = ST_IDLE;
							end else if (r_reg.sh[SA_RW_BIT]) begin
								// Bank register is write only
								if (r_reg.reg_addr == REG_BANK_OFS) begin
									r_next.sda_oe = 1'b0;
									r_next.st = ST_IDLE;
								end
								r_next.ack_to = ST_TX;
								r_next.sh = {1'b0, wiper_sel ? r_reg.wiper : r_reg.stored};
							end else begin
								r_next.ack_to = ST_REG;
							end
						end else if (r_reg.st == ST_REG) begin
							r_next.reg_addr = r_reg.sh;
							r_next.ack_to = r_reg.step ? ST_STEP : ST_DATA;
							if (!(r_reg.sh == REG_WIPER_OFS
								|| (r_reg.sh == REG_BANK_OFS && !r_reg.step))) begin
								r_next.sda_oe = 1'b0;
								r_next.st = ST_IDLE;
							end
						end else begin
							r_next.dat = r_reg.sh;
							r_next.pend = 1'b1;
							r_next.ack_to = ST_WAIT;
						end
					end
				end
				ST_ACK: begin
					if (fall) begin
						r_next.st = r_reg.ack_to;
						r_next.cnt = 4'h0;
						r_next.sda_oe = (r_reg.ack_to == ST_TX) ? ~r_reg.sh[7] : 1'b0;
					end
				end
				ST_STEP: begin
					// Direction bits are never acknowledged
					// Bit held from its rise, applied at its fall: a stop pulse never moves
					if (rise) begin
						r_next.sh[0] = sda;
						r_next.cnt = 4'h1;
					end else if (fall && r_reg.cnt == 4'h1) begin
						r_next.cnt = 4'h0;
						if (wiper_sel) begin
							if (r_reg.sh[0] && r_reg.wiper != WIPER_MAX) begin
								r_next.wiper = r_reg.wiper + 7'h01;
							end else if (!r_reg.sh[0] && r_reg.wiper != WIPER_MIN) begin
								r_next.wiper = r_reg.wiper - 7'h01;
							end
						end
					end
				end
				ST_TX: begin
					if (fall) begin
						if (r_reg.cnt == TX_LAST) begin
							// Master's acknowledge is not awaited
							r_next.sda_oe = 1'b0;
							r_next.st = ST_WAIT;
						end else begin
							r_next.sh = {r_reg.sh[6:0], 1'b0};
							r_next.cnt = r_reg.cnt + 4'h1;
							r_next.sda_oe = ~r_reg.sh[6];
						end
					end
				end
				ST_IDLE, ST_WAIT: begin
				end
				default: begin
					r_next.st = ST_IDLE;
					r_next.sda_oe = 1'b0;
				end
			endcase
		end
		r_next.tap = TAP_N'(1) << r_next.wiper;
	end

	always_ff @(posedge i_clk) begin
		r_reg <= r_next;
	end

	assign o_sda = 1'b0;
	assign o_sda_oe = r_reg.sda_oe;
	assign o_wiper_pos = r_reg.wiper;
	assign o_tap_select = r_reg.tap;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	tap_onehot_a: assert property (##1 $onehot(o_tap_select))
		else $error("tap select not one-hot");
	power_load_a: assert property (disable iff (1'b0)
		!i_rst_n |=> o_wiper_pos == $past(i_stored_wiper))
		else $error("wiper not loaded at reset");
	read_msb_a: assert property (r_reg.st == ST_TX && r_reg.cnt == 4'h0 |-> o_sda_oe)
		else $error("read MSB not zero");
	ack_drive_a: assert property (r_reg.st == ST_ACK |-> o_sda_oe)
		else $error("acknowledge not driven");
	step_up_a: assert property (r_reg.st == ST_STEP && fall && r_reg.cnt == 4'h1
		&& r_reg.sh[0] && wiper_sel && r_reg.wiper != WIPER_MAX
		|=> o_wiper_pos == $past(r_reg.wiper) + 7'h01)
		else $error("step up missed");
	step_sat_a: assert property (r_reg.st == ST_STEP && fall && r_reg.cnt == 4'h1
		&& !r_reg.sh[0] && r_reg.wiper == WIPER_MIN |=> o_wiper_pos == WIPER_MIN)
		else $error("step wrapped below minimum");
	step_noack_a: assert property (r_reg.st == ST_STEP |-> !o_sda_oe)
		else $error("step bits acknowledged");
	addr_miss_a: assert property (r_reg.st == ST_DEV && fall
		&& r_reg.cnt == BYTE_BITS && !addr_ok && !start && !stop
		|=> r_reg.st == ST_IDLE && !o_sda_oe)
		else $error("foreign address answered");
	wiper_cause_a: assert property (r_reg.st != ST_STEP && !stop
		|=> $stable(o_wiper_pos))
		else $error("wiper moved outside write or step");
	bank_commit_a: assert property (stop && r_reg.pend
		&& r_reg.reg_addr == REG_BANK_OFS |=> r_reg.bank == $past(r_reg.dat))
		else $error("bank select not written");

	write_cov: cover property (stop && r_reg.pend && r_reg.reg_addr == REG_WIPER_OFS);
	step_cov: cover property (r_reg.st == ST_STEP && rise ##[1:200] stop);
	read_cov: cover property (r_reg.st == ST_TX && fall && r_reg.cnt == TX_LAST);
	miss_cov: cover property (r_reg.st == ST_DEV && fall && r_reg.cnt == BYTE_BITS && !addr_ok);
endmodule

// File: testbench/wrsa_master.sv
`timescale 1ns/1ps
module wrsa_master (
	// Pacing clock
	input wire logic i_clk,
	// Resolved data line and master drives
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda
);
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	// Quarter of a 48 ns bus period
	task automatic q();
		repeat (3) @(negedge i_clk);
	endtask
	// Leading wait lets the slave release its ack first
	task automatic start();
		q();
		o_sda = 1'b1;
		q();
		o_scl = 1'b1;
		q();
		o_sda = 1'b0;
		q();
		o_scl = 1'b0;
	endtask
	task automatic stop();
		q();
		o_sda = 1'b0;
		q();
		o_scl = 1'b1;
		q();
		o_sda = 1'b1;
		q();
		q();
	endtask
	// Data moves only while the clock is low
	task automatic bit_io(input logic b, output logic s);
		q();
		o_sda = b;
		q();
		o_scl = 1'b1;
		q();
		s = i_sda;
		q();
		o_scl = 1'b0;
	endtask
	task automatic byte_io(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], s);
		end
		bit_io(1'b1, s);
		ack = ~s;
	endtask
endmodule

// File: testbench/wrsa_slave_tb.sv
`timescale 1ns/1ps
module wrsa_slave_tb import wrsa_pkg::*; ();
	// Type codes are arbitrary
	localparam logic [4:0] T_RW = 5'h0c;
	localparam logic [4:0] T_ST = 5'h0d;
	localparam logic [7:0] ADDR_WR = {T_RW, 2'b10, 1'b0};
	localparam logic [7:0] ADDR_RD = {T_RW, 2'b10, 1'b1};
	localparam logic [7:0] ADDR_STEP = {T_ST, 2'b10, 1'b0};
	logic i_clk, i_rst_n, scl, sda_m, sda, o_sda, o_sda_oe, k;
	logic [WIPER_W-1:0] stored, o_wiper_pos;
	logic [TAP_N-1:0] o_tap_select;
	logic [7:0] bad [4];
	int n_fail, tests_run;
	assign sda = sda_m & (o_sda_oe ? o_sda : 1'b1);
	wrsa_master m (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda(sda_m));
	wrsa_slave #(.TYPE_RW(T_RW), .TYPE_STEP(T_ST)) uut (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_scl(scl), .i_sda(sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
		.i_address_select_high(1'b1), .i_address_select_low(1'b0),
		.i_stored_wiper(stored), .o_wiper_pos(o_wiper_pos), .o_tap_select(o_tap_select));
	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end
	task automatic chk(input logic [127:0] s, input logic [127:0] e);
		tests_run++;
		if (s !== e) begin
			n_fail++;
			$display("BAD %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic pos(input logic [6:0] e);
		chk(o_wiper_pos, e);
		chk(o_tap_select, 128'h1 << e);
	endtask
	task automatic hdr(input logic [7:0] a, r, input logic ea, er);
		m.start();
		m.byte_io(a, k);
		chk(k, ea);
		m.byte_io(r, k);
		chk(k, er);
	endtask
	// Register write: header, data byte, stop
	task automatic wr(input logic [7:0] r, v);
		hdr(ADDR_WR, r, 1'b1, 1'b1);
		m.byte_io(v, k);
		chk(k, 1'b1);
		m.stop();
	endtask
	// Read ends with stop right after the eighth bit
	task automatic rd(input logic [7:0] e);
		logic [7:0] d;
		hdr(ADDR_WR, 8'h00, 1'b1, 1'b1);
		m.start();
		m.byte_io(ADDR_RD, k);
		chk(k, 1'b1);
		for (int i = 7; i >= 0; i--) begin
			m.bit_io(1'b1, d[i]);
		end
		m.stop();
		chk(d, e);
	endtask
	task automatic step(input logic [7:0] b, input int n);
		logic s;
		hdr(ADDR_STEP, 8'h00, 1'b1, 1'b1);
		for (int i = 7; i > 7 - n; i--) begin
			m.bit_io(b[i], s);
		end
		m.stop();
	endtask
	initial begin
		repeat (100000) @(posedge i_clk);
		n_fail++;
		tally_and_finish();
	end
	initial begin
		i_rst_n = 1'b0;
		stored = 7'h35;
		bad = '{{T_RW, 2'b01, 1'b0}, {5'h1f, 2'b10, 1'b0}, {T_ST, 2'b10, 1'b1}, ADDR_RD};
		repeat (2) @(negedge i_clk);
		i_rst_n = 1'b1;
		pos(7'h35);
		rd(8'h35);
		wr(8'h02, BANK_WIPER);
		wr(8'h00, 8'hff);
		pos(7'h7f);
		rd(8'h7f);
		// Raises at the top saturate, then two lowers
		step(8'b11100000, 5);
		pos(7'h7d);
		wr(8'h00, 8'h02);
		step(8'b00010000, 4);
		pos(7'h01);
		// Wrong strap, wrong type, step read, read of bank register
		for (int i = 0; i < 3; i++) begin
			hdr(bad[i], 8'h00, 1'b0, 1'b0);
			m.stop();
		end
		hdr(ADDR_WR, 8'h02, 1'b1, 1'b1);
		m.start();
		m.byte_io(bad[3], k);
		chk(k, 1'b0);
		m.stop();
		hdr(ADDR_WR, 8'h05, 1'b1, 1'b0);
		m.stop();
		pos(7'h01);
		wr(8'h02, BANK_STORED);
		// Steps with the stored bank selected leave the wiper alone
		step(8'b11110000, 4);
		pos(7'h01);
		wr(8'h00, 8'h44);
		rd(8'h35);
		pos(7'h01);
		// Power cycle mid-run reloads the new stored value
		stored = 7'h4a;
		i_rst_n = 1'b0;
		repeat (2) @(negedge i_clk);
		i_rst_n = 1'b1;
		pos(7'h4a);
		tally_and_finish();
	end
endmodule
